// File: lcm_pkg.sv
// Purpose: Shared constants and types for the light curtain muting block.
// Assumes: 50 MHz pclk, one scan tick per controller scan cycle.
// Notes: Register map, field positions, reset values and timing counts live here.
package lcm_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
	localparam logic [31:0] OFS_SYNC = 32'h0000_0004;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
	localparam logic [31:0] OFS_INPUTS = 32'h0000_000c;

	// Control register fields.
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_MODE_MSB = 2;

	// Status register fields.
	localparam int ST_GRANT_BIT = 0;
	localparam int ST_MUTE_BIT = 1;
	localparam int ST_FORCE_BIT = 2;
	localparam int ST_FAULT_BIT = 3;
	localparam int ST_CMIS_BIT = 4;
	localparam int ST_OMIS_BIT = 5;
	localparam int ST_SYNC_BIT = 6;
	localparam int ST_SEQ_BIT = 7;
	localparam int ST_STATE_LSB = 8;
	localparam int ST_STATE_MSB = 10;

	// Input vector bit positions.
	localparam int IN_CURT_A = 0;
	localparam int IN_CURT_B = 1;
	localparam int IN_OVR_A = 2;
	localparam int IN_OVR_B = 3;
	localparam int IN_ONE_A = 4;
	localparam int IN_ONE_B = 5;
	localparam int IN_TWO_A = 6;
	localparam int IN_TWO_B = 7;
	localparam int IN_COUNT = 8;

	// Timing: clock, scan cycle, synchronization window, pair mismatch time.
	localparam longint CLK_PERIOD_NS = 20;
	localparam longint SCAN_TIME_NS = 1000000;
	localparam int unsigned SCAN_CYCLES_DEF = 32'(SCAN_TIME_NS / CLK_PERIOD_NS);
	localparam longint SYNC_TIME_S = 3;
	localparam logic [15:0] SYNC_TICKS_DEF = 16'(SYNC_TIME_S * 64'd1000000000 / SCAN_TIME_NS);
	localparam logic [15:0] DISC_TICKS = 16'h001e;

	localparam logic [1:0] MODE_RESET = 2'h1;

	typedef enum logic [1:0] {
		MODE_POS = 2'h0,
		MODE_PAR = 2'h1,
		MODE_FWD = 2'h2,
		MODE_BI = 2'h3
	} lcm_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT_IN = 3'h1,
		ST_WAIT_OUT = 3'h2,
		ST_MUTE_IN = 3'h3,
		ST_MUTE_OUT = 3'h4,
		ST_FORCE = 3'h5
	} lcm_state_t;

endpackage

// File: lcm_muting.sv
// Purpose: Light curtain muting logic with override, pair mismatch and sequence checks.
// Assumes: APB slave on pclk; pins are asynchronous and pass a three-stage filter.
// Notes: All muting decisions and flags update once per scan tick.
//
// Notes on behaviour
// - Curtain pair mismatch drops grant, raises fault; pair inactive-to-active clears it.
// - Override pair mismatch drops grant, raises fault; pair inactive-to-active clears it.
// - Stopped-to-running clears sequence and mismatch errors; muting does not clear sequence.
// - Sync error keeps grant on, fault off; cleared on next normal muting entry.
// - Curtain blocked with sync or sequence error pending drops grant, raises fault.
// - Parallel mode enters muting when one-A then one-B turn on.
// - While muting, grant stays on even with the curtain interrupted.
// - Parallel mode leaves muting when one-A stops detecting.
// - Forward mode mutes after one-A then one-B; leaves when two-A stops.
// - Bidirectional mode also mutes on two-B then two-A.
// - Bidirectional leaves on two-A off entering, one-B off exiting.
// - Position mode mutes when one-A turns on.
// - Position mode unmutes when one-A turns off.
// - Override turning on forces muting, mute-active, grant and force-active.
// - Forced muting ends when one-B stops detecting.
// - Synchronization window defaults to three seconds.
// - Pair onset spacing beyond the window flags sync error, except position mode.
// - Second sensor first, or both together, flags a sequence error.
`timescale 1ns/1ps
module lcm_muting #(
	parameter int unsigned SCAN_CYCLES = lcm_pkg::SCAN_CYCLES_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic light_curtain_input_a,
	input wire logic light_curtain_input_b,
	input wire logic override_input_a,
	input wire logic override_input_b,
	input wire logic sensor_one_a,
	input wire logic sensor_one_b,
	input wire logic sensor_two_a,
	input wire logic sensor_two_b,
	output logic safe_output_grant,
	output logic mute_active,
	output logic force_active,
	output logic fault_flag,
	output logic curtain_mismatch_flag,
	output logic override_mismatch_flag,
	output logic sync_error_flag,
	output logic sequence_error_flag
);
	import lcm_pkg::*;

	logic [IN_COUNT-1:0] pin_raw, s1_reg, s2_reg, s3_reg, filt_reg, prev_reg, rise, fall;
	logic [31:0] scan_cnt_reg, status_word;
	logic tick, run_reg, run_prev_reg, run_rise, timeout, addr_ok;
	lcm_mode_t mode_reg;
	logic [15:0] sync_reg, wait_cnt_reg;
	lcm_state_t state_reg, state_next;
	logic seq_set, sync_set, mute_enter, muted_next, seq_next, sync_next;
	logic c_ok, c_fall, o_on, o_rise, pend_fault, grant_next, fault_next;
	logic [1:0] mis_reg, mis_next;

	assign pin_raw = {sensor_two_b, sensor_two_a, sensor_one_b, sensor_one_a,
		override_input_b, override_input_a, light_curtain_input_b, light_curtain_input_a};

	// Three-stage filter; the first stage feeds only the second.
	generate
		for (genvar i = 0; i < IN_COUNT; i++) begin : g_in
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_reg[i] <= 1'b0;
					s2_reg[i] <= 1'b0;
					s3_reg[i] <= 1'b0;
					filt_reg[i] <= 1'b0;
				end else begin
					s1_reg[i] <= pin_raw[i];
					s2_reg[i] <= s1_reg[i];
					s3_reg[i] <= s2_reg[i];
					if (s2_reg[i] == s3_reg[i]) begin
						filt_reg[i] <= s3_reg[i];
					end
				end
			end
		end
	endgenerate

	// Scan tick generator.
	assign tick = (scan_cnt_reg == SCAN_CYCLES - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_cnt_reg <= 32'h0000_0000;
		end else if (tick) begin
			scan_cnt_reg <= 32'h0000_0000;
		end else begin
			scan_cnt_reg <= scan_cnt_reg + 32'h0000_0001;
		end
	end

	// Edges are taken between two consecutive scans, so a pulse that starts and ends between two ticks is missed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= '0;
			run_prev_reg <= 1'b0;
		end else if (tick) begin
			prev_reg <= filt_reg;
			run_prev_reg <= run_reg;
		end
	end

	assign rise = filt_reg & ~prev_reg;
	assign fall = ~filt_reg & prev_reg;
	assign run_rise = run_reg & ~run_prev_reg;
	assign c_ok = filt_reg[IN_CURT_A] & filt_reg[IN_CURT_B];
	assign c_fall = ~c_ok & prev_reg[IN_CURT_A] & prev_reg[IN_CURT_B];
	assign o_on = filt_reg[IN_OVR_A] & filt_reg[IN_OVR_B];
	assign o_rise = o_on & ~(prev_reg[IN_OVR_A] & prev_reg[IN_OVR_B]);
	assign timeout = (wait_cnt_reg > sync_reg);

	// Pair mismatch checks: index 0 is the curtain pair, 1 the override pair.
	generate
		for (genvar p = 0; p < 2; p++) begin : g_pair
			logic [15:0] cnt_reg;
			logic pair_rise;
			assign pair_rise = filt_reg[2*p] & filt_reg[2*p+1] &
				~(prev_reg[2*p] & prev_reg[2*p+1]);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_reg <= 16'h0000;
				end else if (tick) begin
					if (filt_reg[2*p] == filt_reg[2*p+1]) begin
						cnt_reg <= 16'h0000;
					end else if (cnt_reg != 16'hffff) begin
						cnt_reg <= cnt_reg + 16'h0001;
					end
				end
			end
			// Detection wins over a clear in the same scan.
			always_comb begin
				mis_next[p] = mis_reg[p];
				if (pair_rise || run_rise) begin
					mis_next[p] = 1'b0;
				end
				if (run_reg && cnt_reg >= DISC_TICKS) begin
					mis_next[p] = 1'b1;
				end
			end
		end
	endgenerate

	// Muting sequence decoder.
	always_comb begin
		state_next = state_reg;
		seq_set = 1'b0;
		sync_set = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// The sequence assumes every sensor read inactive beforehand.
				if (mode_reg == MODE_POS) begin
					if (filt_reg[IN_ONE_A]) begin
						state_next = ST_MUTE_IN;
					end else if (c_fall) begin
						seq_set = 1'b1;
					end
				end else if (rise[IN_ONE_A] && rise[IN_ONE_B]) begin
					seq_set = 1'b1;
				end else if (rise[IN_ONE_B] && !filt_reg[IN_ONE_A]) begin
					seq_set = 1'b1;
				end else if (mode_reg != MODE_PAR && (rise[IN_TWO_A] ||
					(rise[IN_TWO_B] && mode_reg == MODE_FWD))) begin
					seq_set = 1'b1;
				end else if (rise[IN_ONE_A]) begin
					state_next = ST_WAIT_IN;
				end else if (mode_reg == MODE_BI && rise[IN_TWO_B]) begin
					state_next = ST_WAIT_OUT;
				end
			end
			ST_WAIT_IN: begin
				if (!filt_reg[IN_ONE_A]) begin
					state_next = ST_IDLE;
				end else if (c_fall || (mode_reg != MODE_PAR &&
					(rise[IN_TWO_A] || rise[IN_TWO_B]))) begin
					seq_set = 1'b1;
					state_next = ST_IDLE;
				end else if (timeout) begin
					sync_set = 1'b1;
					state_next = ST_IDLE;
				end else if (rise[IN_ONE_B]) begin
					state_next = ST_MUTE_IN;
				end
			end
			ST_WAIT_OUT: begin
				if (!filt_reg[IN_TWO_B]) begin
					state_next = ST_IDLE;
				end else if (c_fall || rise[IN_ONE_A] || rise[IN_ONE_B]) begin
					seq_set = 1'b1;
					state_next = ST_IDLE;
				end else if (timeout) begin
					sync_set = 1'b1;
					state_next = ST_IDLE;
				end else if (rise[IN_TWO_A]) begin
					state_next = ST_MUTE_OUT;
				end
			end
			ST_MUTE_IN: begin
				if ((mode_reg == MODE_POS || mode_reg == MODE_PAR) && fall[IN_ONE_A]) begin
					state_next = ST_IDLE;
				end else if ((mode_reg == MODE_FWD || mode_reg == MODE_BI) &&
					fall[IN_TWO_A]) begin
					state_next = ST_IDLE;
				end
			end
			ST_MUTE_OUT: begin
				if (fall[IN_ONE_B]) begin
					state_next = ST_IDLE;
				end
			end
			ST_FORCE: begin
				if (!o_on || fall[IN_ONE_B]) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// Override takes over from any sequence, but not while its own pair disagrees.
		if (o_rise && !mis_next[1]) begin
			state_next = ST_FORCE;
		end
		if (!run_reg) begin
			state_next = ST_IDLE;
			seq_set = 1'b0;
			sync_set = 1'b0;
		end
	end

	assign mute_enter = (state_next == ST_MUTE_IN || state_next == ST_MUTE_OUT) &&
		(state_reg != ST_MUTE_IN && state_reg != ST_MUTE_OUT);
	assign muted_next = (state_next == ST_MUTE_IN || state_next == ST_MUTE_OUT ||
		state_next == ST_FORCE);

	// Error flags: a set in the same scan as a clear wins.
	always_comb begin
		seq_next = sequence_error_flag;
		sync_next = sync_error_flag;
		if (run_rise) begin
			seq_next = 1'b0;
			sync_next = 1'b0;
		end
		if (mute_enter) begin
			sync_next = 1'b0;
		end
		if (seq_set) begin
			seq_next = 1'b1;
		end
		if (sync_set) begin
			sync_next = 1'b1;
		end
	end

	// Mismatch beats everything; override beats a pending error; muting beats a blocked curtain.
	assign pend_fault = (seq_next | sync_next) & ~c_ok;
	assign grant_next = run_reg & ~mis_next[0] & ~mis_next[1] &
		((state_next == ST_FORCE) | (~pend_fault & (muted_next | c_ok)));
	assign fault_next = run_reg & (mis_next[0] | mis_next[1] |
		(pend_fault & (state_next != ST_FORCE)));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
		end else if (tick) begin
			state_reg <= state_next;
		end
	end

	// Synchronization window counter, running only while half a pair has been seen.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt_reg <= 16'h0000;
		end else if (tick) begin
			if (state_next == ST_WAIT_IN || state_next == ST_WAIT_OUT) begin
				if (wait_cnt_reg != 16'hffff) begin
					wait_cnt_reg <= wait_cnt_reg + 16'h0001;
				end
			end else begin
				wait_cnt_reg <= 16'h0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mis_reg <= 2'h0;
			sequence_error_flag <= 1'b0;
			sync_error_flag <= 1'b0;
		end else if (tick) begin
			mis_reg <= mis_next;
			sequence_error_flag <= seq_next;
			sync_error_flag <= sync_next;
		end
	end

	assign curtain_mismatch_flag = mis_reg[0];
	assign override_mismatch_flag = mis_reg[1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			safe_output_grant <= 1'b0;
			fault_flag <= 1'b0;
			mute_active <= 1'b0;
			force_active <= 1'b0;
		end else if (tick) begin
			safe_output_grant <= grant_next;
			fault_flag <= fault_next;
			mute_active <= run_reg & muted_next;
			force_active <= (state_next == ST_FORCE);
		end
	end

	// APB slave: read data is captured in the setup cycle, so the access phase answers at once.
	assign status_word = {21'h00000, state_reg, sequence_error_flag, sync_error_flag,
		mis_reg[1], mis_reg[0], fault_flag, force_active, mute_active, safe_output_grant};
	assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_SYNC) ||
		(paddr == OFS_STATUS) || (paddr == OFS_INPUTS);
	assign pready = 1'b1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !addr_ok;
			prdata <= 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					OFS_CTRL: prdata <= {29'h0000000, mode_reg, run_reg};
					OFS_SYNC: prdata <= {16'h0000, sync_reg};
					OFS_STATUS: prdata <= status_word;
					OFS_INPUTS: prdata <= {24'h000000, filt_reg};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg <= 1'b0;
			mode_reg <= lcm_mode_t'(MODE_RESET);
			sync_reg <= SYNC_TICKS_DEF;
		end else if (psel && penable && pwrite) begin
			if (paddr == OFS_CTRL) begin
				run_reg <= pwdata[CTRL_RUN_BIT];
				mode_reg <= lcm_mode_t'(pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
			end else if (paddr == OFS_SYNC) begin
				sync_reg <= pwdata[15:0];
			end
		end
	end

endmodule

// File: lcm_monitor.sv
// Purpose: Port checker for the light curtain muting block.
// Assumes: Outputs and flags move only on scan tick edges.
// Notes: Bound into every lcm_muting instance.
`timescale 1ns/1ps
module lcm_monitor #(
	parameter int unsigned SCAN_CYCLES = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] paddr,
	input wire logic pslverr,
	input wire logic safe_output_grant,
	input wire logic mute_active,
	input wire logic force_active,
	input wire logic fault_flag,
	input wire logic curtain_mismatch_flag,
	input wire logic override_mismatch_flag,
	input wire logic sync_error_flag,
	input wire logic sequence_error_flag
);
	int unsigned tick_reg;
	logic [7:0] outs;
	assign outs = {sequence_error_flag, sync_error_flag, override_mismatch_flag,
		curtain_mismatch_flag, fault_flag, force_active, mute_active, safe_output_grant};
	// Mirrors the scan tick phase, which restarts with reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_reg <= 0;
		end else begin
			tick_reg <= (tick_reg == SCAN_CYCLES - 1) ? 0 : tick_reg + 1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_tick_only: assert property ($changed(outs) |-> tick_reg == 0)
		else $error("outputs moved off a scan tick");
	a_mute_grant: assert property (mute_active && !fault_flag |-> safe_output_grant)
		else $error("muted without grant");
	a_grant_fault: assert property (fault_flag |-> !safe_output_grant)
		else $error("grant with fault");
	a_fault_cause: assert property (fault_flag |-> outs[7:4] != 4'h0)
		else $error("fault without error flag");
	a_curt_mis: assert property ($rose(curtain_mismatch_flag) |-> fault_flag)
		else $error("curtain mismatch without fault");
	a_ovr_mis: assert property ($rose(override_mismatch_flag) |-> fault_flag)
		else $error("override mismatch without fault");
	a_force_mute: assert property (force_active && outs[5:4] == 2'h0 |-> outs[1:0] == 2'h3)
		else $error("force without mute and grant");
	a_force_end: assert property ($fell(force_active) |-> !mute_active)
		else $error("mute left after force end");
	a_apb_err: assert property (psel && penable |->
		pslverr == (paddr > 32'h0000000c || paddr[1:0] != 2'h0))
		else $error("slave error wrong");
endmodule
bind lcm_muting lcm_monitor #(.SCAN_CYCLES(SCAN_CYCLES)) u_mon (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
	.safe_output_grant(safe_output_grant), .mute_active(mute_active),
	.force_active(force_active), .fault_flag(fault_flag),
	.curtain_mismatch_flag(curtain_mismatch_flag),
	.override_mismatch_flag(override_mismatch_flag),
	.sync_error_flag(sync_error_flag), .sequence_error_flag(sequence_error_flag));

// File: lcm_field.sv
// Purpose: Curtain, override and muting sensor pins seen by the block.
// Assumes: A scene byte in input vector order.
// Notes: Both channels of a pair switch together unless the scene splits them.
`timescale 1ns/1ps
module lcm_field (
	input wire logic [7:0] scene,
	output logic light_curtain_input_a,
	output logic light_curtain_input_b,
	output logic override_input_a,
	output logic override_input_b,
	output logic sensor_one_a,
	output logic sensor_one_b,
	output logic sensor_two_a,
	output logic sensor_two_b
);
	assign {sensor_two_b, sensor_two_a, sensor_one_b, sensor_one_a, override_input_b,
		override_input_a, light_curtain_input_b, light_curtain_input_a} = scene;
endmodule

// File: lcm_muting_tb.sv
// Purpose: Self-checking bench for the light curtain muting block.
// Assumes: Short scan period; each scene is held two or more scans.
// Notes: Output byte order matches the status register.
`timescale 1ns/1ps
module lcm_muting_tb;
	import lcm_pkg::*;
	localparam int unsigned SC = 8;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [7:0] scene, outs;
	logic light_curtain_input_a, light_curtain_input_b, override_input_a, override_input_b;
	logic sensor_one_a, sensor_one_b, sensor_two_a, sensor_two_b;
	logic safe_output_grant, mute_active, force_active, fault_flag;
	logic curtain_mismatch_flag, override_mismatch_flag, sync_error_flag, sequence_error_flag;
	logic [15:0] tbl [4][6];
	int miscompares, num_checks, seed, i, k;
	assign outs = {sequence_error_flag, sync_error_flag, override_mismatch_flag,
		curtain_mismatch_flag, fault_flag, force_active, mute_active, safe_output_grant};
	lcm_field u_field (.scene, .light_curtain_input_a, .light_curtain_input_b,
		.override_input_a, .override_input_b, .sensor_one_a, .sensor_one_b,
		.sensor_two_a, .sensor_two_b);
	lcm_muting #(.SCAN_CYCLES(SC)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .light_curtain_input_a,
		.light_curtain_input_b, .override_input_a, .override_input_b, .sensor_one_a,
		.sensor_one_b, .sensor_two_a, .sensor_two_b, .safe_output_grant, .mute_active,
		.force_active, .fault_flag, .curtain_mismatch_flag, .override_mismatch_flag,
		.sync_error_flag, .sequence_error_flag);
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic wrap_up();
		if (miscompares == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			wrap_up();
		end
	endtask
	// Scene changes on a rising edge; outputs are read at the falling edge to avoid a race.
	task automatic step(input logic [7:0] pins, input logic [7:0] exp, input logic [7:0] msk,
		input int scans);
		scene <= pins;
		repeat (scans * SC) @(posedge pclk);
		@(negedge pclk);
		check(outs & msk, exp);
		@(posedge pclk);
	endtask
	task automatic run(input logic [1:0] md);
		scene <= 8'h03;
		apb(1'b1, OFS_CTRL, 32'h0);
		repeat (2 * SC) @(posedge pclk);
		apb(1'b1, OFS_CTRL, {29'h0, md, 1'b1});
		repeat (2 * SC) @(posedge pclk);
	endtask
	initial begin
		tbl = '{'{16'h1303, 16'h1003, 16'h1303, 16'h0301, 16'h1303, 16'h0301},
			'{16'h1301, 16'h3303, 16'h3003, 16'h3303, 16'h2301, 16'h0301},
			'{16'h1301, 16'h3303, 16'h3003, 16'hf303, 16'hc303, 16'h8301},
			'{16'h8301, 16'hc303, 16'hc003, 16'hf303, 16'h3303, 16'h1301}};
		seed = 32'hb8be2b80;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		scene = 8'h03;
		miscompares = 0;
		num_checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_SYNC, 32'h0);
		check(rd, 32'h00000bb8);
		apb(1'b0, OFS_CTRL, 32'h0);
		check(rd, 32'h00000002);
		apb(1'b0, 32'h00000010, 32'h0);
		check(rerr, 1'b1);
		apb(1'b1, OFS_SYNC, 32'd10 + ($unsigned($random(seed)) % 20));
		for (k = 0; k < 4; k++) begin
			run(k[1:0]);
			for (i = 0; i < 6; i++) begin
				step(tbl[k][i][15:8], tbl[k][i][7:0], 8'hff, 2 + $unsigned($random(seed)) % 2);
			end
		end
		run(2'h1);
		step(($random(seed) & 1) ? 8'h23 : 8'h33, 8'h81, 8'hff, 2);
		step(8'h00, 8'h88, 8'hff, 2);
		step(8'h13, 8'h80, 8'h80, 2);
		step(8'h33, 8'h80, 8'h80, 2);
		run(2'h1);
		step(8'h03, 8'h01, 8'hff, 2);
		apb(1'b1, OFS_SYNC, 32'd3);
		step(8'h13, 8'h41, 8'hff, 8);
		step(8'h00, 8'h48, 8'hff, 2);
		step(8'h13, 8'h40, 8'h40, 2);
		step(8'h33, 8'h03, 8'hff, 2);
		step(8'h23, 8'h01, 8'hff, 2);
		apb(1'b1, OFS_SYNC, 32'd20);
		run(2'h1);
		step(8'h02, 8'h18, 8'hff, 34);
		step(8'h00, 8'h10, 8'h10, 2);
		step(8'h03, 8'h01, 8'hff, 2);
		step(8'h07, 8'h28, 8'hff, 34);
		step(8'h03, 8'h20, 8'h20, 2);
		step(8'h0f, 8'h07, 8'hff, 2);
		step(8'h0c, 8'h07, 8'hff, 2);
		step(8'h2c, 8'h06, 8'h06, 2);
		step(8'h0c, 8'h00, 8'h06, 2);
		run(2'h1);
		step(8'h01, 8'h18, 8'hff, 34);
		step(8'h00, 8'h18, 8'hff, 2);
		// A stop keeps the mismatch flag; only the return to running clears it here.
		apb(1'b1, OFS_CTRL, 32'h0);
		step(8'h00, 8'h10, 8'hff, 2);
		apb(1'b1, OFS_CTRL, 32'h3);
		step(8'h00, 8'h00, 8'hff, 2);
		run(2'h2);
		step(($random(seed) & 1) ? 8'h43 : 8'h83, 8'h81, 8'hff, 2);
		run(2'h3);
		step(8'h13, 8'h01, 8'hff, 2);
		step(8'h33, 8'h03, 8'hff, 2);
		step(8'h70, 8'h03, 8'hff, 2);
		step(8'h43, 8'h03, 8'hff, 2);
		step(8'h03, 8'h01, 8'hff, 2);
		run(2'h0);
		step(8'h00, 8'h88, 8'hff, 2);
		step(8'h03, 8'h81, 8'hff, 2);
		apb(1'b0, OFS_STATUS, 32'h0);
		check(rd, 32'h00000081);
		apb(1'b0, OFS_INPUTS, 32'h0);
		check(rd, 32'h00000003);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		check(outs, 8'h00);
		presetn <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0);
		check(rd, 32'h00000002);
		wrap_up();
	end
endmodule
